// ---- pii_map.vh ----
`ifndef PII_MAP_VH
`define PII_MAP_VH

// Opcodes
`define PII_OP_IN_A_N 8'hDB
`define PII_OP_INR_MASK 8'hC7
`define PII_OP_INR_MATCH 8'h40
`define PII_OP_BLK_INC_ONE 8'hA2
`define PII_OP_BLK_INC_RPT 8'hB2
`define PII_OP_BLK_DEC_ONE 8'hAA
`define PII_OP_BLK_DEC_RPT 8'hBA
`define PII_OP_DIR_BIT 3
`define PII_OP_RPT_BIT 4
`define PII_OP_DST_HI 5
`define PII_OP_DST_LO 3

// Register codes of the destination field
`define PII_REG_B 3'h0
`define PII_REG_C 3'h1
`define PII_REG_D 3'h2
`define PII_REG_E 3'h3
`define PII_REG_H 3'h4
`define PII_REG_L 3'h5
`define PII_REG_F 3'h6
`define PII_REG_A 3'h7

// Flag bit positions
`define PII_FLG_S 7
`define PII_FLG_Z 6
`define PII_FLG_H 4
`define PII_FLG_PV 2
`define PII_FLG_N 1
`define PII_FLG_C 0

// Machine cycle lengths in T-states
`define PII_T_FETCH 3'h4
`define PII_T_FETCH2_BLK 3'h5
`define PII_T_OPND 3'h3
`define PII_T_IO_SINGLE 3'h4
`define PII_T_IO_BLK 3'h3
`define PII_T_MEMW_BLK 3'h4
`define PII_T_RPT 3'h5

// Machine cycle indices
`define PII_M_FIRST 3'h0
`define PII_M_SECOND 3'h1
`define PII_M_THIRD 3'h2
`define PII_M_FOURTH 3'h3
`define PII_M_FIFTH 3'h4

// Refresh T-states inside the repeat cycle
`define PII_RFSH_T0 3'h1
`define PII_RFSH_T1 3'h3

// Timing
`define PII_T_STATE_NS 16
`define PII_CLK_NS 4

`define PII_BYTE_ZERO 8'h00
`define PII_BYTE_ONE 8'h01
`define PII_WORD_ZERO 16'h0000
`define PII_WORD_ONE 16'h0001

`endif

// ---- pii_in_sync.v ----
`timescale 1ns/100ps
`default_nettype none
`include "pii_map.vh"

module pii_in_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk_in,
  input wire srst_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] ff1_r;
  reg [WIDTH-1:0] ff2_r;
  reg [WIDTH-1:0] ff3_r;
  reg [WIDTH-1:0] stable_r;

  // Value only moves once the last two stages agree
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      ff1_r <= {WIDTH{1'b0}};
      ff2_r <= {WIDTH{1'b0}};
      ff3_r <= {WIDTH{1'b0}};
      stable_r <= {WIDTH{1'b0}};
    end else begin
      ff1_r <= async_in;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
      if (ff2_r == ff3_r) begin
        stable_r <= ff3_r;
      end
    end
  end

  assign sync_out = stable_r;

endmodule // pii_in_sync
`default_nettype wire

// ---- pii_regfile.v ----
`timescale 1ns/100ps
`default_nettype none
`include "pii_map.vh"

module pii_regfile (
  input wire ref_clk_in,
  input wire srst_in,
  input wire wr_en_in,
  input wire [2:0] wr_sel_in,
  input wire [7:0] wr_data_in,
  input wire cnt_wr_in,
  input wire [7:0] cnt_data_in,
  input wire [15:0] ptr_data_in,
  input wire flag_wr_in,
  input wire [7:0] flag_data_in,
  output wire [7:0] a_out,
  output wire [7:0] b_out,
  output wire [7:0] c_out,
  output wire [7:0] d_out,
  output wire [7:0] e_out,
  output wire [7:0] h_out,
  output wire [7:0] l_out,
  output wire [7:0] f_out
);

  wire [63:0] q_all;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_reg
      reg [7:0] q_r;
      reg [7:0] q_nxt;
      always @* begin
        q_nxt = q_r;
        if (wr_en_in && (wr_sel_in == gi)) begin
          q_nxt = wr_data_in;
        end
        // Block transfer updates override the generic port
        if (cnt_wr_in && (gi == `PII_REG_B)) begin
          q_nxt = cnt_data_in;
        end
        if (cnt_wr_in && (gi == `PII_REG_H)) begin
          q_nxt = ptr_data_in[15:8];
        end
        if (cnt_wr_in && (gi == `PII_REG_L)) begin
          q_nxt = ptr_data_in[7:0];
        end
        if (flag_wr_in && (gi == `PII_REG_F)) begin
          q_nxt = flag_data_in;
        end
      end
      always @(posedge ref_clk_in) begin
        if (srst_in) begin
          q_r <= `PII_BYTE_ZERO;
        end else begin
          q_r <= q_nxt;
        end
      end
      assign q_all[gi*8 +: 8] = q_r;
    end
  endgenerate

  assign b_out = q_all[8*`PII_REG_B +: 8];
  assign c_out = q_all[8*`PII_REG_C +: 8];
  assign d_out = q_all[8*`PII_REG_D +: 8];
  assign e_out = q_all[8*`PII_REG_E +: 8];
  assign h_out = q_all[8*`PII_REG_H +: 8];
  assign l_out = q_all[8*`PII_REG_L +: 8];
  assign f_out = q_all[8*`PII_REG_F +: 8];
  assign a_out = q_all[8*`PII_REG_A +: 8];

endmodule // pii_regfile
`default_nettype wire

// ---- pii_port_input_unit.v ----
`timescale 1ns/100ps
`default_nettype none
`include "pii_map.vh"

module pii_port_input_unit #(
  parameter T_STATE_NS = `PII_T_STATE_NS,
  parameter CLK_NS = `PII_CLK_NS
) (
  input wire ref_clk_in,
  input wire srst_in,
  input wire start_in,
  input wire prefix_in,
  input wire [7:0] opcode_in,
  input wire [7:0] operand_in,
  input wire int_req_in,
  input wire [7:0] io_data_in,
  input wire reg_load_in,
  input wire [2:0] reg_load_sel_in,
  input wire [7:0] reg_load_data_in,
  output wire busy_out,
  output reg done_out,
  output reg pc_dec2_out,
  output reg int_ack_out,
  output reg [15:0] addr_out,
  output reg io_rd_out,
  output reg mem_wr_out,
  output reg [7:0] mem_data_out,
  output reg m1_out,
  output reg rfsh_out,
  output wire [7:0] a_out,
  output wire [7:0] b_out,
  output wire [7:0] c_out,
  output wire [7:0] d_out,
  output wire [7:0] e_out,
  output wire [7:0] h_out,
  output wire [7:0] l_out,
  output wire [7:0] f_out
);

  // One T-state is a whole number of system clocks, rounded up
  localparam integer T_CLKS_RAW = (T_STATE_NS + CLK_NS - 1) / CLK_NS;
  localparam integer T_CLKS = (T_CLKS_RAW < 1) ? 1 : T_CLKS_RAW;
  localparam integer T_CLK_LAST_I = T_CLKS - 1;
  localparam [7:0] T_CLK_LAST = T_CLK_LAST_I[7:0];

  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  localparam [1:0] CL_IN_A = 2'h0;
  localparam [1:0] CL_IN_R = 2'h1;
  localparam [1:0] CL_BLK = 2'h2;
  localparam [1:0] CL_NONE = 2'h3;

  localparam [2:0] K_FETCH = 3'h0;
  localparam [2:0] K_OPND = 3'h1;
  localparam [2:0] K_IO = 3'h2;
  localparam [2:0] K_MEMW = 3'h3;
  localparam [2:0] K_RPT = 3'h4;

  function [1:0] op_class;
    input pfx;
    input [7:0] op;
    begin
      if (!pfx && op == `PII_OP_IN_A_N) begin
        op_class = CL_IN_A;
      end else if (pfx && ((op & `PII_OP_INR_MASK) == `PII_OP_INR_MATCH)) begin
        op_class = CL_IN_R;
      end else if (pfx && (op == `PII_OP_BLK_INC_ONE || op == `PII_OP_BLK_INC_RPT ||
                           op == `PII_OP_BLK_DEC_ONE || op == `PII_OP_BLK_DEC_RPT)) begin
        op_class = CL_BLK;
      end else begin
        op_class = CL_NONE;
      end
    end
  endfunction

  // Kind and T length of machine cycle m, per instruction class
  function [5:0] phase_info;
    input [1:0] cls;
    input [2:0] m;
    begin
      phase_info = {K_FETCH, `PII_T_FETCH};
      case (cls)
        CL_IN_A: begin
          if (m == `PII_M_SECOND) phase_info = {K_OPND, `PII_T_OPND};
          else if (m == `PII_M_THIRD) phase_info = {K_IO, `PII_T_IO_SINGLE};
        end
        CL_IN_R: begin
          if (m == `PII_M_THIRD) phase_info = {K_IO, `PII_T_IO_SINGLE};
        end
        default: begin
          if (m == `PII_M_SECOND) phase_info = {K_FETCH, `PII_T_FETCH2_BLK};
          else if (m == `PII_M_THIRD) phase_info = {K_IO, `PII_T_IO_BLK};
          else if (m == `PII_M_FOURTH) phase_info = {K_MEMW, `PII_T_MEMW_BLK};
          else if (m == `PII_M_FIFTH) phase_info = {K_RPT, `PII_T_RPT};
        end
      endcase
    end
  endfunction

  reg state_r;
  reg [1:0] cls_r;
  reg [7:0] op_r;
  reg [7:0] opnd_r;
  reg [2:0] m_r;
  reg [2:0] t_r;
  reg [7:0] clk_r;
  reg [7:0] io_byte_r;

  wire [7:0] io_sync;
  wire [5:0] info = phase_info(cls_r, m_r);
  wire [2:0] kind = info[5:3];
  wire [2:0] len = info[2:0];
  wire tick_end = (clk_r == T_CLK_LAST);
  wire m_end = (state_r == ST_RUN) && tick_end && (t_r == len - 3'h1);
  wire [1:0] start_cls = op_class(prefix_in, opcode_in);
  wire accept = (state_r == ST_IDLE) && start_in && (start_cls != CL_NONE);
  wire op_dec = op_r[`PII_OP_DIR_BIT];
  wire op_rpt = op_r[`PII_OP_RPT_BIT];
  wire [2:0] dst = op_r[`PII_OP_DST_HI:`PII_OP_DST_LO];
  wire [15:0] ptr = {h_out, l_out};
  // Counter wraps from zero, so a zero start runs 256 transfers
  wire [7:0] cnt_dec = b_out - `PII_BYTE_ONE;
  wire [15:0] ptr_nxt = op_dec ? (ptr - `PII_WORD_ONE) : (ptr + `PII_WORD_ONE);
  wire more = op_rpt && (cnt_dec != `PII_BYTE_ZERO);

  reg rf_wr_en;
  reg [2:0] rf_wr_sel;
  reg [7:0] rf_wr_data;
  reg cnt_wr;
  reg flag_wr;
  reg [7:0] flag_data;
  reg [15:0] addr_nxt;

  pii_in_sync #(
    .WIDTH(8)
  ) u_data_sync (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .async_in(io_data_in),
    .sync_out(io_sync)
  );

  pii_regfile u_regs (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .wr_en_in(rf_wr_en),
    .wr_sel_in(rf_wr_sel),
    .wr_data_in(rf_wr_data),
    .cnt_wr_in(cnt_wr),
    .cnt_data_in(cnt_dec),
    .ptr_data_in(ptr_nxt),
    .flag_wr_in(flag_wr),
    .flag_data_in(flag_data),
    .a_out(a_out),
    .b_out(b_out),
    .c_out(c_out),
    .d_out(d_out),
    .e_out(e_out),
    .h_out(h_out),
    .l_out(l_out),
    .f_out(f_out)
  );

  // Writeback at the end of the I/O or memory cycle
  always @* begin
    rf_wr_en = 1'b0;
    rf_wr_sel = reg_load_sel_in;
    rf_wr_data = reg_load_data_in;
    cnt_wr = 1'b0;
    flag_wr = 1'b0;
    flag_data = f_out;
    if (state_r == ST_IDLE) begin
      rf_wr_en = reg_load_in;
    end else if (m_end && kind == K_IO && cls_r == CL_IN_A) begin
      rf_wr_en = 1'b1;
      rf_wr_sel = `PII_REG_A;
      rf_wr_data = io_sync;
    end else if (m_end && kind == K_IO && cls_r == CL_IN_R) begin
      // Code 110 has no register behind it: flags only
      rf_wr_en = (dst != `PII_REG_F);
      rf_wr_sel = dst;
      rf_wr_data = io_sync;
      flag_wr = 1'b1;
      flag_data[`PII_FLG_S] = io_sync[7];
      flag_data[`PII_FLG_Z] = (io_sync == `PII_BYTE_ZERO);
      flag_data[`PII_FLG_H] = 1'b0;
      flag_data[`PII_FLG_PV] = ~^io_sync;
      flag_data[`PII_FLG_N] = 1'b0;
    end else if (m_end && kind == K_MEMW) begin
      cnt_wr = 1'b1;
      flag_wr = 1'b1;
      // Undefined flags are simply left as they were
      flag_data[`PII_FLG_Z] = (cnt_dec == `PII_BYTE_ZERO);
      flag_data[`PII_FLG_N] = 1'b1;
    end
  end

  always @* begin
    addr_nxt = `PII_WORD_ZERO;
    if (state_r == ST_RUN && kind == K_IO) begin
      if (cls_r == CL_IN_A) begin
        addr_nxt = {a_out, opnd_r};
      end else begin
        addr_nxt = {b_out, c_out};
      end
    end else if (state_r == ST_RUN && kind == K_MEMW) begin
      addr_nxt = ptr;
    end
  end

  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_r <= ST_IDLE;
      cls_r <= CL_IN_A;
      op_r <= `PII_BYTE_ZERO;
      opnd_r <= `PII_BYTE_ZERO;
      m_r <= `PII_M_FIRST;
      t_r <= 3'h0;
      clk_r <= 8'h00;
      io_byte_r <= `PII_BYTE_ZERO;
      done_out <= 1'b0;
      pc_dec2_out <= 1'b0;
      int_ack_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      pc_dec2_out <= 1'b0;
      int_ack_out <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept) begin
            state_r <= ST_RUN;
            cls_r <= start_cls;
            op_r <= opcode_in;
            opnd_r <= operand_in;
            m_r <= `PII_M_FIRST;
            t_r <= 3'h0;
            clk_r <= 8'h00;
          end
        end
        default: begin
          clk_r <= tick_end ? 8'h00 : clk_r + 8'h01;
          if (tick_end) begin
            t_r <= m_end ? 3'h0 : t_r + 3'h1;
          end
          if (m_end) begin
            m_r <= m_r + 3'h1;
            if (kind == K_IO) begin
              io_byte_r <= io_sync;
              if (cls_r != CL_BLK) begin
                state_r <= ST_IDLE;
                done_out <= 1'b1;
              end
            end else if (kind == K_MEMW && !more) begin
              state_r <= ST_IDLE;
              done_out <= 1'b1;
            end else if (kind == K_RPT) begin
              pc_dec2_out <= 1'b1;
              // Between bytes is the only safe point to break a long transfer
              if (int_req_in) begin
                int_ack_out <= 1'b1;
                state_r <= ST_IDLE;
                done_out <= 1'b1;
              end else begin
                m_r <= `PII_M_FIRST;
              end
            end
          end
        end
      endcase
    end
  end

  // Bus strobes registered, so they trail the phase by one clock
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      addr_out <= `PII_WORD_ZERO;
      io_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_data_out <= `PII_BYTE_ZERO;
      m1_out <= 1'b0;
      rfsh_out <= 1'b0;
    end else begin
      addr_out <= addr_nxt;
      io_rd_out <= (state_r == ST_RUN) && (kind == K_IO);
      mem_wr_out <= (state_r == ST_RUN) && (kind == K_MEMW);
      mem_data_out <= io_byte_r;
      m1_out <= (state_r == ST_RUN) && (kind == K_FETCH);
      rfsh_out <= (state_r == ST_RUN) && (kind == K_RPT) &&
                  (t_r == `PII_RFSH_T0 || t_r == `PII_RFSH_T1);
    end
  end

  assign busy_out = (state_r == ST_RUN);

endmodule // pii_port_input_unit
`default_nettype wire

// ---- pii_chk_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module pii_chk #(
  parameter T_STATE_NS = 16,
  parameter CLK_NS = 4
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic reg_load_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic int_ack_out,
  input wire logic pc_dec2_out,
  input wire logic [15:0] addr_out,
  input wire logic io_rd_out,
  input wire logic mem_wr_out,
  input wire logic m1_out,
  input wire logic rfsh_out,
  input wire logic [7:0] h_out,
  input wire logic [7:0] l_out,
  input wire logic [7:0] f_out
);
  localparam int TC = (T_STATE_NS + CLK_NS - 1) / CLK_NS;
  logic [7:0] io_len_r;
  logic [7:0] mem_len_r;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);
  always @(posedge ref_clk_in) begin
    io_len_r <= (srst_in || !io_rd_out) ? 8'h00 : io_len_r + 8'h01;
    mem_len_r <= (srst_in || !mem_wr_out) ? 8'h00 : mem_len_r + 8'h01;
  end
  // Refresh pattern assumes four clocks per T-state
  sequence two_rfsh;
    rfsh_out [*4] ##1 !rfsh_out [*4] ##1 rfsh_out [*4] ##1 !rfsh_out;
  endsequence
  io_len_a: assert property ($fell(io_rd_out) |-> io_len_r == 3 * TC || io_len_r == 4 * TC)
    else $error("io cycle length wrong");
  mem_len_a: assert property ($fell(mem_wr_out) |-> mem_len_r == 4 * TC)
    else $error("memory cycle length wrong");
  mem_addr_a: assert property ($rose(mem_wr_out) |-> addr_out == {h_out, l_out})
    else $error("memory address not pointer");
  addr_hold_a: assert property ((io_rd_out && $past(io_rd_out)) || (mem_wr_out && $past(mem_wr_out)) |-> $stable(addr_out))
    else $error("address moved within a cycle");
  bus_excl_a: assert property (!(io_rd_out && mem_wr_out) && !(m1_out && (io_rd_out || mem_wr_out)))
    else $error("bus cycle kinds overlap");
  addr_idle_a: assert property (!io_rd_out && !mem_wr_out |-> addr_out == 16'h0000)
    else $error("address not idle");
  rfsh_pair_a: assert property ($rose(rfsh_out) && !$past(rfsh_out, 5) |-> two_rfsh)
    else $error("refresh pair malformed");
  int_exit_a: assert property (int_ack_out |-> done_out && pc_dec2_out)
    else $error("interrupt exit without done");
  done_pulse_a: assert property (done_out |-> !busy_out ##1 !done_out)
    else $error("done not a single pulse");
  carry_keep_a: assert property (!$past(reg_load_in) && !$past(reg_load_in, 2) |-> $stable(f_out[0]))
    else $error("carry flag changed");
endmodule // pii_chk
bind pii_port_input_unit pii_chk #(.T_STATE_NS(T_STATE_NS), .CLK_NS(CLK_NS)) chk (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in), .reg_load_in(reg_load_in), .busy_out(busy_out),
  .done_out(done_out), .int_ack_out(int_ack_out), .pc_dec2_out(pc_dec2_out),
  .addr_out(addr_out), .io_rd_out(io_rd_out), .mem_wr_out(mem_wr_out), .m1_out(m1_out),
  .rfsh_out(rfsh_out), .h_out(h_out), .l_out(l_out), .f_out(f_out));
`default_nettype wire

// ---- pii_io_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pii_io_model (
  input wire logic ref_clk_in,
  input wire logic io_rd_out,
  input wire logic [1:0] lag_in,
  output logic [7:0] io_data_in
);
  logic [7:0] pend [$];
  logic [7:0] cur = 8'h00;
  int age = 0;
  initial io_data_in = 8'h5a;
  always @(posedge ref_clk_in) begin
    if (!io_rd_out) begin
      age = 0;
      // Released bus toggles so stale data cannot pass
      io_data_in <= ~io_data_in;
    end else begin
      if (age == 0 && pend.size() > 0)
        cur = pend.pop_front();
      io_data_in <= (age >= lag_in) ? cur : ~cur;
      age = age + 1;
    end
  end
endmodule // pii_io_model
`default_nettype wire

// ---- pii_port_input_unit_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module pii_port_input_unit_tb;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic start_in = 1'b0;
  logic prefix_in = 1'b0;
  logic int_req_in = 1'b0;
  logic reg_load_in = 1'b0;
  logic [7:0] opcode_in = 8'h00;
  logic [7:0] operand_in = 8'h00;
  logic [7:0] reg_load_data_in = 8'h00;
  logic [2:0] reg_load_sel_in = 3'h0;
  logic [1:0] lag = 2'h0;
  wire [7:0] io_data_in;
  wire busy_out, done_out, pc_dec2_out, int_ack_out, io_rd_out, mem_wr_out, m1_out, rfsh_out;
  wire [15:0] addr_out;
  wire [7:0] mem_data_out, a_out, b_out, c_out, d_out, e_out, h_out, l_out, f_out;
  logic [7:0] rg [0:7];
  logic [63:0] ex_io [$];
  logic [63:0] ex_mem [$];
  logic [63:0] ex_end [$];
  logic [63:0] ex_tim [$];
  logic [63:0] te;
  logic [63:0] mk;
  logic [15:0] t_run = 16'h0000;
  logic [15:0] pdc = 16'h0000;
  logic [15:0] m1c = 16'h0000;
  logic pio = 1'b0;
  logic pmem = 1'b0;
  logic [7:0] ops [0:3] = '{8'ha2, 8'haa, 8'hb2, 8'hba};
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;

  always #2 ref_clk_in = ~ref_clk_in;

  pii_port_input_unit #(.T_STATE_NS(16), .CLK_NS(4)) DUT (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .start_in(start_in), .prefix_in(prefix_in),
    .opcode_in(opcode_in), .operand_in(operand_in), .int_req_in(int_req_in),
    .io_data_in(io_data_in), .reg_load_in(reg_load_in), .reg_load_sel_in(reg_load_sel_in),
    .reg_load_data_in(reg_load_data_in), .busy_out(busy_out), .done_out(done_out),
    .pc_dec2_out(pc_dec2_out), .int_ack_out(int_ack_out), .addr_out(addr_out),
    .io_rd_out(io_rd_out), .mem_wr_out(mem_wr_out), .mem_data_out(mem_data_out),
    .m1_out(m1_out), .rfsh_out(rfsh_out), .a_out(a_out), .b_out(b_out), .c_out(c_out),
    .d_out(d_out), .e_out(e_out), .h_out(h_out), .l_out(l_out), .f_out(f_out));

  pii_io_model mdl (.ref_clk_in(ref_clk_in), .io_rd_out(io_rd_out), .lag_in(lag),
    .io_data_in(io_data_in));

  task automatic results();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (e !== g) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [63:0] regs();
    return {rg[7], rg[0], rg[1], rg[2], rg[3], rg[4], rg[5], rg[6]};
  endfunction

  always @(posedge ref_clk_in) begin
    cyc++;
    t_run <= (start_in && !busy_out) ? 16'h0000 : t_run + 16'h0001;
    if (cyc == 80000) begin
      fails++;
      results();
    end
  end

  always @(negedge ref_clk_in) begin
    if (io_rd_out && !pio)
      cmp("io address", ex_io.pop_front(), {48'h0, addr_out});
    if (mem_wr_out && !pmem)
      cmp("mem write", ex_mem.pop_front(), {40'h0, addr_out, mem_data_out});
    if (pc_dec2_out)
      pdc++;
    if (m1_out)
      m1c++;
    if (done_out) begin
      te = ex_tim.pop_front();
      mk = {56'hff_ffff_ffff_ffff, te[24:17]};
      cmp("end time", {47'h0, te[16:0]}, {47'h0, int_ack_out, t_run});
      cmp("end regs", ex_end.pop_front() & mk, {a_out, b_out, c_out, d_out, e_out, h_out,
        l_out, f_out} & mk);
      cmp("repeat rewinds", {48'h0, te[40:25]}, {48'h0, pdc});
      cmp("fetch clocks", {48'h0, te[56:41]}, {48'h0, m1c});
      pdc = 16'h0000;
      m1c = 16'h0000;
    end
    pio = io_rd_out;
    pmem = mem_wr_out;
  end

  task automatic load(input logic [2:0] s, input logic [7:0] v);
    @(negedge ref_clk_in);
    reg_load_in = 1'b1;
    reg_load_sel_in = s;
    reg_load_data_in = v;
    @(negedge ref_clk_in);
    reg_load_in = 1'b0;
    rg[s] = v;
  endtask

  task automatic issue(input logic p, input logic [7:0] op, input logic [7:0] n,
      input logic irq, input logic [7:0] mask, input logic ack, input logic [15:0] t,
      input logic [15:0] nr, input logic [15:0] mf);
    int k;
    ex_end.push_back(regs());
    ex_tim.push_back({7'h0, mf, nr, mask, ack, t});
    @(negedge ref_clk_in);
    lag = 2'($urandom);
    int_req_in = irq;
    prefix_in = p;
    opcode_in = op;
    operand_in = n;
    start_in = 1'b1;
    @(negedge ref_clk_in);
    // Start and preset while busy must both be ignored
    prefix_in = 1'b0;
    opcode_in = 8'hdb;
    reg_load_in = 1'b1;
    reg_load_sel_in = 3'h7;
    reg_load_data_in = ~rg[7];
    @(negedge ref_clk_in);
    start_in = 1'b0;
    reg_load_in = 1'b0;
    k = 0;
    while (done_out !== 1'b1 && k < 30000) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (done_out !== 1'b1) begin
      fails++;
      results();
    end
  endtask

  task automatic in_imm(input logic [7:0] n);
    logic [7:0] d;
    d = 8'($urandom);
    mdl.pend.push_back(d);
    ex_io.push_back({48'h0, rg[7], n});
    rg[7] = d;
    issue(1'b0, 8'hdb, n, 1'b0, 8'hff, 1'b0, 16'(11 * 4), 16'h0000, 16'(4 * 4));
  endtask

  task automatic in_reg(input logic [2:0] r, input logic [7:0] d);
    logic [7:0] f;
    mdl.pend.push_back(d);
    ex_io.push_back({48'h0, rg[0], rg[1]});
    if (r != 3'h6)
      rg[r] = d;
    f = rg[6];
    rg[6] = {d[7], d == 8'h00, f[5], 1'b0, f[3], ~^d, 1'b0, f[0]};
    issue(1'b1, {2'b01, r, 3'b000}, 8'h00, 1'b0, 8'hd7, 1'b0, 16'(12 * 4), 16'h0000,
      16'(8 * 4));
  endtask

  task automatic blk(input logic [7:0] op, input logic irq);
    logic [7:0] d;
    logic [15:0] hl;
    int t;
    int nr;
    int nb;
    t = 0;
    nr = 0;
    nb = 0;
    forever begin
      d = 8'($urandom);
      mdl.pend.push_back(d);
      ex_io.push_back({48'h0, rg[0], rg[1]});
      hl = {rg[4], rg[5]};
      ex_mem.push_back({40'h0, hl, d});
      rg[0] = rg[0] - 8'h01;
      hl = op[3] ? hl - 16'h0001 : hl + 16'h0001;
      {rg[4], rg[5]} = hl;
      rg[6][6] = (rg[0] == 8'h00);
      rg[6][1] = 1'b1;
      t = t + 16 * 4;
      nb++;
      if (!op[4] || rg[0] == 8'h00)
        break;
      t = t + 5 * 4;
      nr++;
      if (irq)
        break;
    end
    issue(1'b1, op, 8'h00, irq, 8'h6b, op[4] && rg[0] != 8'h00, 16'(t), 16'(nr),
      16'(9 * 4 * nb));
  endtask

  initial begin
    void'($urandom(9));
    repeat (12) @(negedge ref_clk_in);
    srst_in = 1'b0;
    for (i = 0; i < 8; i++)
      load(i[2:0], 8'($urandom));
    in_imm(8'h00);
    in_imm(8'($urandom));
    for (i = 0; i < 8; i++)
      in_reg(i[2:0], (i == 2) ? 8'h00 : (i == 4) ? 8'h80 : 8'($urandom));
    load(3'h0, 8'h05);
    blk(8'hba, 1'b1);
    for (i = 0; i < 4; i++) begin
      load(3'h0, 8'h01);
      blk(ops[i], 1'b0);
      blk(ops[i], 1'b0);
    end
    @(negedge ref_clk_in);
    prefix_in = 1'b1;
    opcode_in = 8'h41;
    start_in = 1'b1;
    @(negedge ref_clk_in);
    start_in = 1'b0;
    @(negedge ref_clk_in);
    cmp("busy on foreign opcode", 64'h0, {63'h0, busy_out});
    results();
  end
endmodule // pii_port_input_unit_tb
`default_nettype wire
